//--- acsw_pkg.sv
// Shared constants, field positions and carrier types for the auxiliary status word bank.
package acsw_pkg;

	// -------------------------------------------------------------------------
	// Timing
	// -------------------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned TENTH_MS_NS = 100000;
	localparam int unsigned TENTH_MS_CYCLES = TENTH_MS_NS / CLK_PERIOD_NS;
	localparam int unsigned SECOND_NS = 1000000000;
	localparam int unsigned SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;

	// -------------------------------------------------------------------------
	// Word offsets
	// -------------------------------------------------------------------------
	localparam logic [7:0] OFS_LINK1_SVC = 8'h11;
	localparam logic [7:0] OFS_SEC_MIN = 8'h12;
	localparam logic [7:0] OFS_HOUR_DAY = 8'h13;
	localparam logic [7:0] OFS_MONTH_YEAR = 8'h14;
	localparam logic [7:0] OFS_WDAY_CTRL = 8'h15;
	localparam logic [7:0] OFS_KEYMAP = 8'h16;
	localparam logic [7:0] OFS_PWR_COUNT = 8'h17;
	localparam logic [7:0] OFS_PRESENCE = 8'h18;
	localparam logic [7:0] OFS_LOCK_TRACE = 8'h19;
	localparam logic [7:0] OFS_MAX_SCAN = 8'h1A;
	localparam logic [7:0] OFS_CUR_SCAN = 8'h1B;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h1C;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h1D;

	// -------------------------------------------------------------------------
	// Field positions
	// -------------------------------------------------------------------------
	localparam int unsigned BIT_COMP = 13;
	localparam int unsigned BIT_STOP = 14;
	localparam int unsigned BIT_SET = 15;
	localparam int unsigned BIT_FPD_TRIG = 8;
	localparam int unsigned BIT_EDIT_DIS = 9;
	localparam int unsigned BIT_EDIT_STBY = 10;
	localparam int unsigned BIT_TRACE_END = 12;
	localparam int unsigned BIT_TRACING = 13;
	localparam int unsigned BIT_TRACE_TRIG = 14;
	localparam int unsigned BIT_TRACE_START = 15;
	localparam int unsigned BIT_CYCLE_FLAG = 5;
	localparam int unsigned BIT_NETPAR_L1 = 6;
	localparam int unsigned BIT_NETPAR_L0 = 7;
	localparam logic [7:0] EDIT_PASSWORD = 8'h5A;
	localparam logic [15:0] PRESENCE_UNIT_MASK = 16'hFB0F;
	localparam logic [7:0] HALF_MINUTE = 8'h30;

	// Interrupt status bits.
	localparam int unsigned IRQ_MINUTE = 0;
	localparam int unsigned IRQ_TRACE_END = 1;
	localparam int unsigned IRQ_POWER = 2;
	localparam int unsigned IRQ_NEW_MAX = 3;
	localparam int unsigned IRQ_W = 4;

	// -------------------------------------------------------------------------
	// Reset values
	// -------------------------------------------------------------------------
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [7:0] DAY_RST = 8'h01;
	localparam logic [7:0] MONTH_RST = 8'h01;

	// -------------------------------------------------------------------------
	// Carrier types
	// -------------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] year;
		logic [7:0] month;
		logic [7:0] wday;
		logic [7:0] day;
		logic [7:0] hour;
		logic [7:0] min;
		logic [7:0] sec;
	} acsw_cal_s;

	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} acsw_bus_s;

	typedef struct packed {
		logic [15:0] link1_service_time;
		logic [15:0] unit_present;
		logic cycle_time_flag;
		logic [1:0] net_param_flag;
		logic edit_standby;
		logic tracing;
		logic trace_done;
		logic power_restored;
		logic scan_end;
	} acsw_status_in_s;

endpackage

//--- acsw_bank.sv
// Auxiliary status word bank: calendar clock, counters, flags, edit lock and scan timing.
`timescale 1ns/1ps

module acsw_bank import acsw_pkg::*; #(
	parameter int unsigned SEC_CYCLES = SECOND_CYCLES
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Register port
	input wire acsw_bus_s bus_req,
	output logic [15:0] rd_data,
	// Status from the controller
	input wire acsw_status_in_s st_in,
	// Control outputs
	output logic edit_lock,
	output logic fpd_trigger,
	output logic trace_start,
	output logic trace_trigger,
	output logic irq
);

	// -------------------------------------------------------------------------
	// Declarations
	// -------------------------------------------------------------------------
	acsw_cal_s cal_r, cal_nxt, shadow_r;
	logic stop_r, set_pend_r, comp_pend_r;
	logic [15:0] keymap_r, pwr_cnt_r, presence_r, svc_r;
	logic [7:0] password_r;
	logic fpd_r, edit_dis_r, trace_start_r, trace_trig_r, trace_end_r;
	logic [15:0] max_scan_r, cur_scan_r, scan_acc_r;
	logic [25:0] sec_cnt_r;
	logic [11:0] tms_cnt_r;
	logic sec_tick, tms_tick, minute_roll;
	logic [IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_event;
	logic [15:0] rd_data_r, rd_mux;
	logic edit_lock_r, irq_r;
	logic wr_ctrl;

	assign wr_ctrl = bus_req.wr && bus_req.addr == OFS_WDAY_CTRL;

	// -------------------------------------------------------------------------
	// BCD helpers
	// -------------------------------------------------------------------------
	// Next BCD value of a two-digit byte.
	function automatic logic [7:0] bcd_inc8(input logic [7:0] v);
		if (v[3:0] == 4'h9) begin
			bcd_inc8 = {v[7:4] + 4'h1, 4'h0};
		end else begin
			bcd_inc8 = {v[7:4], v[3:0] + 4'h1};
		end
	endfunction

	// Last day of the month; year 00 counts as a leap year.
	function automatic logic [7:0] month_days(input logic [7:0] mon, input logic [7:0] yr);
		logic leap;
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
			: (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
		case (mon)
			8'h02: month_days = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
			default: month_days = 8'h31;
		endcase
	endfunction

	// -------------------------------------------------------------------------
	// Timebases
	// -------------------------------------------------------------------------
	// One-second and tenth-millisecond ticks keep running whatever the mode.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			sec_cnt_r <= 26'h0000000;
		end else if (sec_tick) begin
			sec_cnt_r <= 26'h0000000;
		end else begin
			sec_cnt_r <= sec_cnt_r + 26'h0000001;
		end
	end
	assign sec_tick = sec_cnt_r == 26'(SEC_CYCLES - 1);

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			tms_cnt_r <= 12'h000;
		end else if (tms_tick) begin
			tms_cnt_r <= 12'h000;
		end else begin
			tms_cnt_r <= tms_cnt_r + 12'h001;
		end
	end
	assign tms_tick = tms_cnt_r == 12'(TENTH_MS_CYCLES - 1);

	// -------------------------------------------------------------------------
	// Calendar
	// -------------------------------------------------------------------------
	// Writes to the calendar words land in a shadow; the set bit moves them live.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			shadow_r <= '{year: 8'h00, month: MONTH_RST, wday: 8'h00, day: DAY_RST,
				hour: 8'h00, min: 8'h00, sec: 8'h00};
		end else if (bus_req.wr) begin
			case (bus_req.addr)
				OFS_SEC_MIN: {shadow_r.min, shadow_r.sec} <= bus_req.wdata;
				OFS_HOUR_DAY: {shadow_r.day, shadow_r.hour} <= bus_req.wdata;
				OFS_MONTH_YEAR: {shadow_r.year, shadow_r.month} <= bus_req.wdata;
				OFS_WDAY_CTRL: shadow_r.wday <= bus_req.wdata[7:0];
				default: shadow_r <= shadow_r;
			endcase
		end
	end

	// Control bits: stop persists, set and compensation act once and clear.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			stop_r <= 1'b0;
			set_pend_r <= 1'b0;
			comp_pend_r <= 1'b0;
		end else if (wr_ctrl) begin
			stop_r <= bus_req.wdata[BIT_STOP];
			set_pend_r <= bus_req.wdata[BIT_SET];
			comp_pend_r <= bus_req.wdata[BIT_COMP];
		end else begin
			set_pend_r <= 1'b0;
			comp_pend_r <= 1'b0;
		end
	end

	// Next calendar value: set load first, then compensation, then the second tick.
	always_comb begin
		logic adv;
		adv = sec_tick && !stop_r;
		cal_nxt = cal_r;
		minute_roll = 1'b0;
		if (set_pend_r) begin
			cal_nxt = shadow_r;
			adv = 1'b0;
		end else if (comp_pend_r) begin
			if (cal_r.sec < HALF_MINUTE) begin
				cal_nxt.sec = 8'h00;
				adv = 1'b0;
			end else begin
				cal_nxt.sec = 8'h59;
				adv = 1'b1;
			end
		end
		if (adv) begin
			if (cal_nxt.sec == 8'h59) begin
				cal_nxt.sec = 8'h00;
				minute_roll = 1'b1;
				if (cal_nxt.min == 8'h59) begin
					cal_nxt.min = 8'h00;
					if (cal_nxt.hour == 8'h23) begin
						cal_nxt.hour = 8'h00;
						cal_nxt.wday = (cal_nxt.wday >= 8'h06) ? 8'h00 : bcd_inc8(cal_nxt.wday);
						if (cal_nxt.day >= month_days(cal_nxt.month, cal_nxt.year)) begin
							cal_nxt.day = 8'h01;
							if (cal_nxt.month >= 8'h12) begin
								cal_nxt.month = 8'h01;
								cal_nxt.year = (cal_nxt.year == 8'h99) ? 8'h00 : bcd_inc8(cal_nxt.year);
							end else begin
								cal_nxt.month = bcd_inc8(cal_nxt.month);
							end
						end else begin
							cal_nxt.day = bcd_inc8(cal_nxt.day);
						end
					end else begin
						cal_nxt.hour = bcd_inc8(cal_nxt.hour);
					end
				end else begin
					cal_nxt.min = bcd_inc8(cal_nxt.min);
				end
			end else begin
				cal_nxt.sec = bcd_inc8(cal_nxt.sec);
			end
		end
	end

	// Live calendar; only resetn clears it, never a mode change.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cal_r <= '{year: 8'h00, month: MONTH_RST, wday: 8'h00, day: DAY_RST,
				hour: 8'h00, min: 8'h00, sec: 8'h00};
		end else begin
			cal_r <= cal_nxt;
		end
	end

	// -------------------------------------------------------------------------
	// Counters and sampled status
	// -------------------------------------------------------------------------
	// Power interruption count, four BCD digits, wrapping 9999 to 0000.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pwr_cnt_r <= WORD_RST;
		end else if (st_in.power_restored) begin
			if (pwr_cnt_r[7:0] == 8'h99) begin
				pwr_cnt_r <= {(pwr_cnt_r[15:8] == 8'h99) ? 8'h00 : bcd_inc8(pwr_cnt_r[15:8]), 8'h00};
			end else begin
				pwr_cnt_r <= {pwr_cnt_r[15:8], bcd_inc8(pwr_cnt_r[7:0])};
			end
		end
	end

	// Service time and presence word are sampled every cycle.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			svc_r <= WORD_RST;
			presence_r <= WORD_RST;
		end else begin
			svc_r <= st_in.link1_service_time;
			presence_r <= (st_in.unit_present & PRESENCE_UNIT_MASK)
				| (16'(st_in.cycle_time_flag) << BIT_CYCLE_FLAG)
				| (16'(st_in.net_param_flag[1]) << BIT_NETPAR_L1)
				| (16'(st_in.net_param_flag[0]) << BIT_NETPAR_L0);
		end
	end

	// Scan time in tenths of a millisecond, saturating; latched at each scan end.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			scan_acc_r <= WORD_RST;
			cur_scan_r <= WORD_RST;
			max_scan_r <= WORD_RST;
		end else if (st_in.scan_end) begin
			scan_acc_r <= WORD_RST;
			cur_scan_r <= scan_acc_r;
			if (scan_acc_r > max_scan_r) begin
				max_scan_r <= scan_acc_r;
			end
		end else if (tms_tick && scan_acc_r != 16'hFFFF) begin
			scan_acc_r <= scan_acc_r + 16'h0001;
		end
	end

	// -------------------------------------------------------------------------
	// User words: keyboard mapping, edit lock and trace control
	// -------------------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			keymap_r <= WORD_RST;
		end else if (bus_req.wr && bus_req.addr == OFS_KEYMAP) begin
			keymap_r <= bus_req.wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			password_r <= 8'h00;
			fpd_r <= 1'b0;
			edit_dis_r <= 1'b0;
			trace_trig_r <= 1'b0;
			trace_start_r <= 1'b0;
		end else if (bus_req.wr && bus_req.addr == OFS_LOCK_TRACE) begin
			password_r <= bus_req.wdata[7:0];
			fpd_r <= bus_req.wdata[BIT_FPD_TRIG];
			edit_dis_r <= bus_req.wdata[BIT_EDIT_DIS];
			trace_trig_r <= bus_req.wdata[BIT_TRACE_TRIG];
			trace_start_r <= bus_req.wdata[BIT_TRACE_START];
		end
	end

	// Trace end is set by the tracer and cleared by a new trace start; set wins.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			trace_end_r <= 1'b0;
		end else if (st_in.trace_done) begin
			trace_end_r <= 1'b1;
		end else if (bus_req.wr && bus_req.addr == OFS_LOCK_TRACE && bus_req.wdata[BIT_TRACE_START]) begin
			trace_end_r <= 1'b0;
		end
	end

	// Lock output is honoured only with the password present.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			edit_lock_r <= 1'b0;
		end else begin
			edit_lock_r <= edit_dis_r && password_r == EDIT_PASSWORD;
		end
	end

	// -------------------------------------------------------------------------
	// Interrupts
	// -------------------------------------------------------------------------
	assign irq_event[IRQ_MINUTE] = minute_roll;
	assign irq_event[IRQ_TRACE_END] = st_in.trace_done;
	assign irq_event[IRQ_POWER] = st_in.power_restored;
	assign irq_event[IRQ_NEW_MAX] = st_in.scan_end && scan_acc_r > max_scan_r;

	// Sticky status, write one to clear; a new event in the same cycle wins.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			irq_stat_r <= '0;
			irq_mask_r <= '0;
			irq_r <= 1'b0;
		end else begin
			if (bus_req.wr && bus_req.addr == OFS_IRQ_STATUS) begin
				irq_stat_r <= (irq_stat_r & ~bus_req.wdata[IRQ_W-1:0]) | irq_event;
			end else begin
				irq_stat_r <= irq_stat_r | irq_event;
			end
			if (bus_req.wr && bus_req.addr == OFS_IRQ_MASK) begin
				irq_mask_r <= bus_req.wdata[IRQ_W-1:0];
			end
			irq_r <= |(irq_stat_r & irq_mask_r);
		end
	end

	// -------------------------------------------------------------------------
	// Read port
	// -------------------------------------------------------------------------
	// Calendar words read live; unmapped offsets read zero.
	always_comb begin
		case (bus_req.addr)
			OFS_LINK1_SVC: rd_mux = svc_r;
			OFS_SEC_MIN: rd_mux = {cal_r.min, cal_r.sec};
			OFS_HOUR_DAY: rd_mux = {cal_r.day, cal_r.hour};
			OFS_MONTH_YEAR: rd_mux = {cal_r.year, cal_r.month};
			OFS_WDAY_CTRL: rd_mux = {set_pend_r, stop_r, comp_pend_r, 5'h00, cal_r.wday};
			OFS_KEYMAP: rd_mux = keymap_r;
			OFS_PWR_COUNT: rd_mux = pwr_cnt_r;
			OFS_PRESENCE: rd_mux = presence_r;
			OFS_LOCK_TRACE: rd_mux = {trace_start_r, trace_trig_r, st_in.tracing, trace_end_r, 1'b0,
				st_in.edit_standby, edit_dis_r, fpd_r, password_r};
			OFS_MAX_SCAN: rd_mux = max_scan_r;
			OFS_CUR_SCAN: rd_mux = cur_scan_r;
			OFS_IRQ_STATUS: rd_mux = {12'h000, irq_stat_r};
			OFS_IRQ_MASK: rd_mux = {12'h000, irq_mask_r};
			default: rd_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rd_data_r <= WORD_RST;
		end else if (bus_req.rd) begin
			rd_data_r <= rd_mux;
		end else begin
			rd_data_r <= WORD_RST;
		end
	end

	// Outputs come straight from flip-flops.
	assign rd_data = rd_data_r;
	assign edit_lock = edit_lock_r;
	assign fpd_trigger = fpd_r;
	assign trace_start = trace_start_r;
	assign trace_trigger = trace_trig_r;
	assign irq = irq_r;

	// -------------------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	sequence svc_read_s;
		bus_req.rd && bus_req.addr == OFS_LINK1_SVC;
	endsequence

	sequence comp_up_s;
		wr_ctrl && bus_req.wdata[BIT_COMP] && !bus_req.wdata[BIT_SET] && cal_r.sec >= HALF_MINUTE;
	endsequence

	svc_read_a: assert property (svc_read_s |=> rd_data == $past(svc_r))
		else $error("Service time word read back wrong.");
	sec_range_a: assert property (cal_r.sec <= 8'h59 && cal_r.min <= 8'h59 && cal_r.hour <= 8'h23)
		else $error("Time field out of range.");
	day_range_a: assert property (cal_r.day >= 8'h01 && cal_r.day <= month_days(cal_r.month, cal_r.year))
		else $error("Day of month out of range.");
	month_range_a: assert property (cal_r.month >= 8'h01 && cal_r.month <= 8'h12 && cal_r.year <= 8'h99)
		else $error("Month or year out of range.");
	wday_range_a: assert property (cal_r.wday <= 8'h06)
		else $error("Weekday out of range.");
	stop_hold_a: assert property (stop_r && !set_pend_r && !comp_pend_r && !wr_ctrl |=> $stable(cal_r))
		else $error("Calendar moved while stopped.");
	comp_round_a: assert property (comp_up_s ##1 !set_pend_r |=> cal_r.sec == 8'h00 && cal_r.min != $past(cal_r.min, 2))
		else $error("Compensation did not round up.");
	pwr_count_a: assert property (st_in.power_restored |=> pwr_cnt_r != $past(pwr_cnt_r) && pwr_cnt_r[3:0] <= 4'h9)
		else $error("Power count not advanced in BCD.");
	edit_lock_a: assert property (edit_lock |-> $past(password_r) == EDIT_PASSWORD && $past(edit_dis_r))
		else $error("Edit lock without password.");
	trace_end_a: assert property (st_in.trace_done |=> trace_end_r ##1 (trace_end_r || $past(bus_req.wr)))
		else $error("Trace end flag not held.");
	max_scan_a: assert property (st_in.scan_end |=> max_scan_r >= cur_scan_r && cur_scan_r == $past(scan_acc_r))
		else $error("Scan time words inconsistent.");

endmodule

//--- acsw_bank_tb.sv
// Self-checking testbench for the auxiliary status word bank.
`timescale 1ns/1ps

module acsw_bank_tb import acsw_pkg::*; ;
	// ----------
	// Signals
	// ----------
	localparam int unsigned SEC_N = 50;
	logic sys_clk = 1'b0;
	logic resetn;
	acsw_bus_s bus_req;
	acsw_status_in_s st_in;
	logic [15:0] rd_data;
	logic edit_lock, fpd_trigger, trace_start, trace_trigger, irq;
	int n_mismatch = 0;
	int comparisons = 0;
	logic [15:0] v;
	// Calendar cases at 23:59:59: day and hour in, month and year in, and the expected next values.
	logic [15:0] hd_in [6] = '{16'h3123, 16'h2823, 16'h2823, 16'h2923, 16'h3023, 16'h3123};
	logic [15:0] my_in [6] = '{16'h2401, 16'h2302, 16'h2402, 16'h2402, 16'h2404, 16'h9912};
	logic [15:0] hd_ex [6] = '{16'h0100, 16'h0100, 16'h2900, 16'h0100, 16'h0100, 16'h0100};
	logic [15:0] my_ex [6] = '{16'h2402, 16'h2303, 16'h2402, 16'h2403, 16'h2405, 16'h0001};

	// The short second keeps calendar rollovers within a few hundred cycles.
	acsw_bank #(.SEC_CYCLES(SEC_N)) dut_u (.sys_clk(sys_clk), .resetn(resetn), .bus_req(bus_req),
		.rd_data(rd_data), .st_in(st_in), .edit_lock(edit_lock), .fpd_trigger(fpd_trigger),
		.trace_start(trace_start), .trace_trigger(trace_trigger), .irq(irq));

	// Clock at 40 MHz.
	always #12.5 sys_clk = ~sys_clk;

	// ----------
	// Tasks
	// ----------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask

	// A write is one cycle with the strobe high.
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		bus_req.addr <= a;
		bus_req.wdata <= d;
		bus_req.wr <= 1'b1;
		@(posedge sys_clk);
		bus_req.wr <= 1'b0;
	endtask

	// A read takes the data in the cycle after the strobe, once it has settled.
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		bus_req.addr <= a;
		bus_req.rd <= 1'b1;
		@(posedge sys_clk);
		bus_req.rd <= 1'b0;
		#1;
		d = rd_data;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e, input string w);
		logic [15:0] d;
		rd(a, d);
		chk(d & m, e, w);
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// One-cycle event pulse: 0 power back, 1 trace done, else scan end.
	task automatic pulse(input int k);
		@(posedge sys_clk);
		case (k)
			0: st_in.power_restored <= 1'b1;
			1: st_in.trace_done <= 1'b1;
			default: st_in.scan_end <= 1'b1;
		endcase
		@(posedge sys_clk);
		st_in.power_restored <= 1'b0;
		st_in.trace_done <= 1'b0;
		st_in.scan_end <= 1'b0;
	endtask

	// Loads the calendar with the clock stopped.
	task automatic set_cal(input logic [15:0] sm, input logic [15:0] hd, input logic [15:0] my, input logic [7:0] wd);
		wr(OFS_SEC_MIN, sm);
		wr(OFS_HOUR_DAY, hd);
		wr(OFS_MONTH_YEAR, my);
		wr(OFS_WDAY_CTRL, {8'hC0, wd});
	endtask

	task automatic report_and_stop();
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ----------
	// Tests
	// ----------
	initial begin
		bus_req = '0;
		st_in = '0;
		resetn = 1'b0;
		repeat (8) @(posedge sys_clk);
		resetn <= 1'b1;
		for (int a = 'h11; a <= 'h1D; a++) begin
			rchk(a[7:0], 16'hFFFF, (a == 'h13) ? 16'h0100 : ((a == 'h14) ? 16'h0001 : 16'h0000), "reset");
		end
		@(posedge sys_clk);
		st_in.link1_service_time <= 16'h1234;
		st_in.unit_present <= 16'hFFFF;
		st_in.cycle_time_flag <= 1'b1;
		st_in.net_param_flag <= 2'b01;
		wr(OFS_LINK1_SVC, 16'hFFFF);
		rchk(OFS_LINK1_SVC, 16'hFFFF, 16'h1234, "service time");
		rchk(OFS_PRESENCE, 16'hFFFF, 16'hFBAF, "presence");
		@(posedge sys_clk);
		st_in.unit_present <= 16'h0000;
		st_in.cycle_time_flag <= 1'b0;
		st_in.net_param_flag <= 2'b10;
		wr(OFS_PRESENCE, 16'hFFFF);
		rchk(OFS_PRESENCE, 16'hFFFF, 16'h0040, "presence low");
		wr(OFS_KEYMAP, 16'hA5C3);
		rchk(OFS_KEYMAP, 16'hFFFF, 16'hA5C3, "keymap");
		rchk(8'h30, 16'hFFFF, 16'h0000, "unmapped");
		// Midnight rollovers across month ends, leap years and the year wrap.
		for (int i = 0; i < 6; i++) begin
			set_cal(16'h5959, hd_in[i], my_in[i], 8'(6 - i));
			repeat (2 * SEC_N) @(posedge sys_clk);
			rchk(OFS_SEC_MIN, 16'hFFFF, 16'h5959, "stopped");
			wr(OFS_WDAY_CTRL, 16'h0006);
			v = 16'h5959;
			for (int j = 0; j < 60 && v === 16'h5959; j++) begin
				rd(OFS_SEC_MIN, v);
			end
			chk(v, 16'h0000, "sec min");
			rchk(OFS_HOUR_DAY, 16'hFFFF, hd_ex[i], "hour day");
			rchk(OFS_MONTH_YEAR, 16'hFFFF, my_ex[i], "month year");
			rchk(OFS_WDAY_CTRL, 16'hFFFF, 16'((i == 0) ? 0 : 7 - i), "weekday");
		end
		// Compensation both ways, with unused control bits written as ones on the round up and as zeros on the round down.
		set_cal(16'h1045, 16'h0101, 16'h2401, 8'h03);
		wr(OFS_WDAY_CTRL, 16'h7F03);
		repeat (3) @(posedge sys_clk);
		rchk(OFS_SEC_MIN, 16'hFFFF, 16'h1100, "round up");
		rchk(OFS_WDAY_CTRL, 16'hFFFF, 16'h4003, "control");
		set_cal(16'h1029, 16'h0101, 16'h2401, 8'h03);
		wr(OFS_WDAY_CTRL, 16'h6003);
		repeat (3) @(posedge sys_clk);
		rchk(OFS_SEC_MIN, 16'hFFFF, 16'h1000, "round down");
		// Edit lock, diagnosis trigger and trace bits.
		wr(OFS_LOCK_TRACE, 16'h025A);
		settle(3);
		chk({15'h0, edit_lock}, 16'h0001, "lock on");
		wr(OFS_LOCK_TRACE, 16'h0259);
		settle(3);
		chk({15'h0, edit_lock}, 16'h0000, "lock bad key");
		wr(OFS_LOCK_TRACE, 16'hC100);
		settle(3);
		chk({12'h0, fpd_trigger, trace_start, trace_trigger, edit_lock}, 16'h000E, "outputs");
		@(posedge sys_clk);
		st_in.edit_standby <= 1'b1;
		st_in.tracing <= 1'b1;
		pulse(1);
		rchk(OFS_LOCK_TRACE, 16'hFF00, 16'hF500, "trace status");
		wr(OFS_LOCK_TRACE, 16'h8000);
		@(posedge sys_clk);
		st_in.edit_standby <= 1'b0;
		st_in.tracing <= 1'b0;
		rchk(OFS_LOCK_TRACE, 16'hFF00, 16'h8000, "trace restart");
		// Power count in BCD, its event masked then unmasked and cleared.
		wr(OFS_IRQ_MASK, 16'h0000);
		rchk(OFS_IRQ_STATUS, 16'hFFFF, 16'h0003, "minute and trace events");
		wr(OFS_IRQ_STATUS, 16'h000F);
		rchk(OFS_IRQ_STATUS, 16'hFFFF, 16'h0000, "status clear");
		for (int k = 0; k < 11; k++) begin
			pulse(0);
		end
		wr(OFS_PWR_COUNT, 16'h0000);
		rchk(OFS_PWR_COUNT, 16'hFFFF, 16'h0011, "power count");
		rchk(OFS_IRQ_STATUS, 16'hFFFF, 16'h0004, "power event");
		settle(3);
		chk({15'h0, irq}, 16'h0000, "irq masked");
		wr(OFS_IRQ_MASK, 16'h0004);
		settle(3);
		chk({15'h0, irq}, 16'h0001, "irq on");
		wr(OFS_IRQ_STATUS, 16'h0004);
		settle(3);
		chk({15'h0, irq}, 16'h0000, "irq cleared");
		// A long scan then a short one; the tick phase leaves one tenth of slack.
		wr(OFS_IRQ_MASK, 16'h0008);
		pulse(2);
		wr(OFS_IRQ_STATUS, 16'h0008);
		repeat (3 * TENTH_MS_CYCLES) @(posedge sys_clk);
		pulse(2);
		repeat (TENTH_MS_CYCLES) @(posedge sys_clk);
		pulse(2);
		rd(OFS_MAX_SCAN, v);
		chk({15'h0, v == 16'h0003 || v == 16'h0004}, 16'h0001, "max scan");
		rd(OFS_CUR_SCAN, v);
		chk({15'h0, v == 16'h0001 || v == 16'h0002}, 16'h0001, "cur scan");
		chk({15'h0, irq}, 16'h0001, "new max irq");
		report_and_stop();
	end

	// Watchdog well beyond the expected run length.
	initial begin
		repeat (60000) @(posedge sys_clk);
		n_mismatch++;
		$display("[ERR] %0t watchdog expired", $time);
		report_and_stop();
	end
endmodule
